/* File: logic/pts_pkg.sv */
// Functional notes
// - Stay idle until frame or a pending stop request; a hit with frame goes straight to data.
// - From idle, a stop request from this target leads to the release wait.
// - From idle, frame seen without a valid hit leads to bus busy.
// - Bus busy waits for the bus to go idle; no exit to data or wait.
// - Data state moves data; frame with stop asserted leads to the release wait.
// - Reads get one wait state before target ready is asserted.
// - After stop, hold the release wait until the master drops frame.
// - A finished transaction passes through turnaround before the bus is released.
// - Latch the command lines in the address phase; later they carry byte enables.
// - Parity is even over address/data and the four command/byte-enable lines.
// - On writes the master side drives parity from local byte parity and the byte enables.
// - On writes the target flags a parity error on received data.
// - On reads the master side drives parity error from the local parity check.
// - The target sequencer shares no state with any master sequencer.
// - A read hit supplies data, signals a target abort, or stops without data on a terminate request.
// - Decode takes no wait states; no resource locking exists.
// - Command codes follow bus encoding; 0010 is an input/output read.
package pts_pkg;

    localparam int unsigned PTS_AD_W = 32;
    localparam logic [3:0] PTS_CMD_IO_READ = 4'h2;
    localparam logic [3:0] PTS_CMD_IO_WRITE = 4'h3;
    localparam logic [3:0] PTS_CMD_MEM_READ = 4'h6;
    localparam logic [3:0] PTS_CMD_MEM_WRITE = 4'h7;
    localparam logic [3:0] PTS_CMD_RESET = 4'h0;
    localparam int unsigned PTS_READ_WAIT = 1;
    localparam int unsigned PTS_BUF_DEPTH = 2;

    typedef enum logic [2:0] {
        PTS_IDLE = 3'b000,
        PTS_BUSY = 3'b001,
        PTS_DATA = 3'b010,
        PTS_STOP_RELEASE_WAIT = 3'b011,
        PTS_TURN = 3'b100
    } pts_state_type;

    typedef struct packed {
        logic [PTS_AD_W-1:0] data;
        logic [3:0] byte_en;
    } pts_word_type;

endpackage

/* File: logic/pts_buf.sv */
`timescale 1ns/1ns
// =============================================================
// Two-entry skid buffer between the bus and the backend.
module pts_buf
    import pts_pkg::*;
#(
    parameter int unsigned DEPTH = PTS_BUF_DEPTH
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic arst_n,
    // Filling side.
    input wire logic in_valid,
    output logic in_ready,
    input wire pts_word_type in_word,
    // Draining side.
    output logic out_valid,
    input wire logic out_ready,
    output pts_word_type out_word
);
    initial begin
        if (DEPTH != 2) begin
            $error("pts_buf supports only two entries");
        end
    end

    pts_word_type mem_ff [2];
    logic wr_ptr_ff;
    logic rd_ptr_ff;
    logic [1:0] count_ff;
    logic push;
    logic pop;

    assign in_ready = (count_ff != 2'h2);
    assign out_valid = (count_ff != 2'h0);
    assign out_word = mem_ff[rd_ptr_ff];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            mem_ff[0] <= '0;
            mem_ff[1] <= '0;
        end else if (push) begin
            mem_ff[wr_ptr_ff] <= in_word;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr_ff <= 1'b0;
            rd_ptr_ff <= 1'b0;
            count_ff <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr_ff <= ~wr_ptr_ff;
            end
            if (pop) begin
                rd_ptr_ff <= ~rd_ptr_ff;
            end
            count_ff <= count_ff + {1'b0, push} - {1'b0, pop};
        end
    end

    a_buf_no_overflow: assert property (@(posedge clock) disable iff (!arst_n)
        count_ff == 2'h2 && !out_ready |=> count_ff == 2'h2 && $stable(out_word))
        else $error("full buffer lost or changed a word");
endmodule

/* File: logic/pts_target.sv */
`timescale 1ns/1ns
// =============================================================
// Bus target sequencer. Bus pins are sampled on clock here
// through two flip-flops; backend signals share the clock.
module pts_target
    import pts_pkg::*;
(
    // Clock and reset.
    input wire logic clock,
    input wire logic arst_n,
    // Bus inputs, active low where named so.
    input wire logic frame_n,
    input wire logic irdy_n,
    input wire logic [PTS_AD_W-1:0] ad_in,
    input wire logic [3:0] cbe_in,
    input wire logic par_in,
    // Bus outputs with enables, high while driving.
    output logic trdy_n_out,
    output logic trdy_oe,
    output logic stop_n_out,
    output logic stop_oe,
    output logic devsel_n_out,
    output logic devsel_oe,
    output logic perr_n_out,
    output logic perr_oe,
    output logic par_out,
    output logic par_oe,
    output logic [PTS_AD_W-1:0] ad_out,
    output logic ad_oe,
    // Local processor parity side.
    input wire logic [3:0] processor_byte_parity,
    input wire logic processor_parity_check_n,
    // Decoder and backend.
    input wire logic hit,
    input wire logic terminate,
    input wire logic abort,
    input wire logic rd_valid,
    output logic rd_ready,
    input wire logic [PTS_AD_W-1:0] rd_data,
    output logic wr_valid,
    input wire logic wr_ready,
    output pts_word_type wr_word,
    output logic [3:0] cmd,
    output logic cmd_is_read,
    output logic target_abort
);
    // =========================================================
    // Pin synchronisers.
    logic [1:0] frame_sync_ff;
    logic [1:0] irdy_sync_ff;
    logic [PTS_AD_W-1:0] ad_sync0_ff;
    logic [PTS_AD_W-1:0] ad_sync1_ff;
    logic [3:0] cbe_sync0_ff;
    logic [3:0] cbe_sync1_ff;
    logic [1:0] par_sync_ff;
    logic [1:0] processor_parity_check_sync_ff;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            frame_sync_ff <= 2'h3;
            irdy_sync_ff <= 2'h3;
            ad_sync0_ff <= '0;
            ad_sync1_ff <= '0;
            cbe_sync0_ff <= 4'h0;
            cbe_sync1_ff <= 4'h0;
            par_sync_ff <= 2'h0;
            processor_parity_check_sync_ff <= 2'h3;
        end else begin
            frame_sync_ff <= {frame_sync_ff[0], frame_n};
            irdy_sync_ff <= {irdy_sync_ff[0], irdy_n};
            ad_sync0_ff <= ad_in;
            ad_sync1_ff <= ad_sync0_ff;
            cbe_sync0_ff <= cbe_in;
            cbe_sync1_ff <= cbe_sync0_ff;
            par_sync_ff <= {par_sync_ff[0], par_in};
            processor_parity_check_sync_ff <= {processor_parity_check_sync_ff[0], processor_parity_check_n};
        end
    end

    logic frame_a;
    logic irdy_a;
    assign frame_a = !frame_sync_ff[1];
    assign irdy_a = !irdy_sync_ff[1];

    // =========================================================
    // Sequencer. It keeps no state shared with any master logic.
    pts_state_type state_ff;
    pts_state_type nxt_state;
    logic stop_req_ff;
    logic wait_done_ff;
    logic [3:0] cmd_ff;
    logic is_read;
    logic data_ok;
    logic buf_in_ready;

    assign is_read = !cmd_ff[0];

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            PTS_IDLE: begin
                if (hit && frame_a) begin
                    nxt_state = PTS_DATA;
                end else if (stop_req_ff) begin
                    nxt_state = PTS_STOP_RELEASE_WAIT;
                end else if (frame_a) begin
                    nxt_state = PTS_BUSY;
                end
            end
            PTS_BUSY: begin
                if (!frame_a && !irdy_a) begin
                    nxt_state = PTS_IDLE;
                end
            end
            PTS_DATA: begin
                if (frame_a && (terminate || abort)) begin
                    nxt_state = PTS_STOP_RELEASE_WAIT;
                end else if (!frame_a && data_ok) begin
                    nxt_state = PTS_TURN;
                end
            end
            PTS_STOP_RELEASE_WAIT: begin
                if (!frame_a) begin
                    nxt_state = PTS_TURN;
                end
            end
            PTS_TURN: nxt_state = PTS_IDLE;
            default: nxt_state = PTS_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= PTS_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // A stop request outside a transfer is held until the sequencer
    // has entered the release wait.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            stop_req_ff <= 1'b0;
        end else if (state_ff == PTS_IDLE && terminate) begin
            stop_req_ff <= 1'b1;
        end else if (state_ff == PTS_STOP_RELEASE_WAIT) begin
            stop_req_ff <= 1'b0;
        end
    end

    // =========================================================
    // Command latch, loaded only in the address phase.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cmd_ff <= PTS_CMD_RESET;
        end else if (state_ff == PTS_IDLE && frame_a) begin
            cmd_ff <= cbe_sync1_ff;
        end
    end

    assign cmd = cmd_ff;
    assign cmd_is_read = is_read;

    // =========================================================
    // Read wait state: ready is held back for one cycle after entry.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wait_done_ff <= 1'b0;
        end else if (state_ff == PTS_DATA) begin
            wait_done_ff <= 1'b1;
        end else begin
            wait_done_ff <= 1'b0;
        end
    end

    logic ready_now;
    assign ready_now = (state_ff == PTS_DATA) && !abort
        && (is_read ? (wait_done_ff && rd_valid) : buf_in_ready);
    assign data_ok = ready_now && irdy_a;

    // =========================================================
    // Write path through the two-entry buffer so a backend stall
    // shows as a withheld ready and no word is lost.
    pts_word_type buf_in;
    assign buf_in.data = ad_sync1_ff;
    assign buf_in.byte_en = cbe_sync1_ff;

    pts_buf #(
        .DEPTH(PTS_BUF_DEPTH)
    ) u_buf (
        .clock(clock),
        .arst_n(arst_n),
        .in_valid(data_ok && !is_read),
        .in_ready(buf_in_ready),
        .in_word(buf_in),
        .out_valid(wr_valid),
        .out_ready(wr_ready),
        .out_word(wr_word)
    );

    assign rd_ready = data_ok && is_read;

    // =========================================================
    // Bus drive. Nothing is driven in busy or after reset; in idle only perr stays driven, for the first cycle after turnaround.
    logic drive_ff;
    logic trdy_ff;
    logic stop_ff;
    logic [PTS_AD_W-1:0] ad_ff;
    logic ad_oe_ff;
    logic abort_ff;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            drive_ff <= 1'b0;
            trdy_ff <= 1'b0;
            stop_ff <= 1'b0;
            ad_ff <= '0;
            ad_oe_ff <= 1'b0;
            abort_ff <= 1'b0;
        end else begin
            drive_ff <= (nxt_state == PTS_DATA) || (nxt_state == PTS_STOP_RELEASE_WAIT)
                || (nxt_state == PTS_TURN);
            trdy_ff <= ready_now;
            stop_ff <= (nxt_state == PTS_STOP_RELEASE_WAIT);
            ad_oe_ff <= (state_ff == PTS_DATA) && is_read && wait_done_ff;
            if (rd_ready) begin
                ad_ff <= rd_data;
            end
            abort_ff <= (state_ff == PTS_DATA) && abort;
        end
    end

    // Turnaround keeps the enables up and returns the other lines to
    // their inactive level. Ready is registered, so the last accepted
    // phase still shows there; gating it would hide that phase.
    logic active;
    assign active = drive_ff && (state_ff != PTS_TURN);
    assign trdy_n_out = !(trdy_ff && drive_ff);
    assign stop_n_out = !(stop_ff && active);
    assign devsel_n_out = !(active && !abort_ff);
    assign trdy_oe = drive_ff;
    assign stop_oe = drive_ff;
    assign devsel_oe = drive_ff;
    assign ad_out = ad_ff;
    assign ad_oe = ad_oe_ff;
    assign target_abort = abort_ff;

    // =========================================================
    // Parity. Even parity over data and the four command lines.
    logic par_ff;
    logic par_oe_ff;
    logic perr_ff;
    logic perr_oe_ff;
    logic wr_phase_ff;
    logic par_calc;

    // Local byte parity bits stand in for the data lines' own parity.
    assign par_calc = (^processor_byte_parity) ^ (^cbe_sync1_ff);

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            par_ff <= 1'b0;
            par_oe_ff <= 1'b0;
            perr_ff <= 1'b0;
            perr_oe_ff <= 1'b0;
            wr_phase_ff <= 1'b0;
        end else begin
            wr_phase_ff <= data_ok && !is_read;
            par_ff <= par_calc;
            par_oe_ff <= (state_ff == PTS_DATA) && !is_read;
            if (wr_phase_ff) begin
                perr_ff <= ((^buf_in.data) ^ (^buf_in.byte_en)) != par_sync_ff[1];
            end else if ((state_ff == PTS_DATA) && is_read) begin
                perr_ff <= !processor_parity_check_sync_ff[1];
            end else begin
                perr_ff <= 1'b0;
            end
            perr_oe_ff <= drive_ff;
        end
    end

    assign par_out = par_ff;
    assign par_oe = par_oe_ff;
    assign perr_n_out = !perr_ff;
    assign perr_oe = perr_oe_ff;

    // =========================================================
    // Checks.
    a_idle_hit_data: assert property (@(posedge clock) disable iff (!arst_n)
        state_ff == PTS_IDLE && hit && frame_a |=> state_ff == PTS_DATA)
        else $error("hit did not start data");
    a_idle_stop_wait: assert property (@(posedge clock) disable iff (!arst_n)
        state_ff == PTS_IDLE && !(hit && frame_a) && stop_req_ff
        |=> state_ff == PTS_STOP_RELEASE_WAIT)
        else $error("stop in idle did not reach release wait");
    a_idle_busy_go: assert property (@(posedge clock) disable iff (!arst_n)
        state_ff == PTS_IDLE && frame_a && !hit && !stop_req_ff |=> state_ff == PTS_BUSY)
        else $error("frame without hit did not reach busy");
    a_busy_no_data: assert property (@(posedge clock) disable iff (!arst_n)
        state_ff == PTS_BUSY |=> state_ff inside {PTS_BUSY, PTS_IDLE})
        else $error("busy left to a wrong state");
    a_data_stop_go: assert property (@(posedge clock) disable iff (!arst_n)
        state_ff == PTS_DATA && frame_a && terminate |=> state_ff == PTS_STOP_RELEASE_WAIT)
        else $error("frame with stop did not reach release wait");
    a_read_wait_one: assert property (@(posedge clock) disable iff (!arst_n)
        $rose(state_ff == PTS_DATA) && is_read |-> !ready_now ##1 !trdy_ff)
        else $error("read ready without wait state");
    a_wait_hold_frame: assert property (@(posedge clock) disable iff (!arst_n)
        state_ff == PTS_STOP_RELEASE_WAIT && frame_a |=> state_ff == PTS_STOP_RELEASE_WAIT)
        else $error("release wait left while frame held");
    a_turn_to_idle: assert property (@(posedge clock) disable iff (!arst_n)
        state_ff == PTS_TURN |=> state_ff == PTS_IDLE ##1 !drive_ff || state_ff != PTS_IDLE)
        else $error("turnaround did not return to idle");
    a_cmd_held_data: assert property (@(posedge clock) disable iff (!arst_n)
        state_ff == PTS_DATA && $past(state_ff) == PTS_DATA |-> $stable(cmd_ff))
        else $error("command latch changed during data");
endmodule

/* File: bench/pts_master_model.sv */
`timescale 1ns/1ns
// =============================================================
// Bus master stand-in. Released lines without a pull-up show the
// inverse of their last value, so late sampling of them is caught.
module pts_master_model
    import pts_pkg::*;
(
    // Clock.
    input wire logic clock,
    // Lines driven toward the target.
    output logic frame_n,
    output logic irdy_n,
    output logic [PTS_AD_W-1:0] ad_in,
    output logic [3:0] cbe_in,
    output logic par_in,
    // Target drive on the shared lines.
    input wire logic trdy_n_out,
    input wire logic trdy_oe,
    input wire logic stop_n_out,
    input wire logic stop_oe,
    input wire logic [PTS_AD_W-1:0] ad_out,
    input wire logic ad_oe,
    input wire logic par_out,
    input wire logic par_oe
);
    logic [PTS_AD_W-1:0] m_ad = '0;
    logic m_par = 1'b0;
    int done_cnt = 0;

    assign ad_in = ad_oe ? ad_out : m_ad;
    assign par_in = par_oe ? par_out : m_par;

    initial begin
        frame_n = 1'b1;
        irdy_n = 1'b1;
        cbe_in = 4'h0;
    end

    task automatic cycle(input logic [3:0] c, input logic [31:0] a, input logic [31:0] d,
        input logic [3:0] be, input bit hold, input bit badp,
        output bit got, output int lat, output logic [31:0] rd);
        bit quit;
        got = 0;
        lat = 0;
        rd = '0;
        quit = 0;
        @(negedge clock);
        frame_n = 1'b0;
        m_ad = a;
        cbe_in = c;
        m_par = ^{a, c};
        @(negedge clock);
        frame_n = !hold;
        irdy_n = 1'b0;
        cbe_in = be;
        m_ad = c[0] ? d : ~a;
        m_par = ^{d, be} ^ badp;
        while (!got && !quit) begin
            @(posedge clock);
            lat++;
            if (trdy_oe === 1'b1 && trdy_n_out === 1'b0) begin
                got = 1;
                rd = ad_in;
            end
            quit = (stop_oe === 1'b1 && stop_n_out === 1'b0) || lat >= 60;
            @(negedge clock);
            if (!c[0] && !got && !quit) m_ad = ~m_ad;
        end
        // A stopped master must give up frame before irdy.
        if (hold) frame_n = 1'b1;
        if (hold) @(negedge clock);
        irdy_n = 1'b1;
        m_ad = ~m_ad;
        cbe_in = ~cbe_in;
        m_par = ~m_par;
        done_cnt += got;
    endtask
endmodule

/* File: bench/tb_top.sv */
`timescale 1ns/1ns
// =============================================================
// Self-checking bench for the target sequencer.
module tb_top
    import pts_pkg::*;
;
    logic clock, arst_n, frame_n, irdy_n, par_in, trdy_n_out, trdy_oe, stop_n_out, stop_oe;
    logic devsel_n_out, devsel_oe, perr_n_out, perr_oe, par_out, par_oe, ad_oe;
    logic processor_parity_check_n, hit, terminate, abort, rd_valid, rd_ready;
    logic wr_valid, wr_ready, cmd_is_read, target_abort;
    logic [PTS_AD_W-1:0] ad_in, ad_out, rd_data, rd;
    logic [3:0] cbe_in, processor_byte_parity, cmd;
    pts_word_type wr_word;
    pts_word_type exp_q[$];
    int seed, lat, wlat, p0, n0, s0, t0, d0, bad_count, comparisons;
    bit got;

    pts_target u_dut (.clock, .arst_n, .frame_n, .irdy_n, .ad_in, .cbe_in, .par_in,
        .trdy_n_out, .trdy_oe, .stop_n_out, .stop_oe, .devsel_n_out, .devsel_oe,
        .perr_n_out, .perr_oe, .par_out, .par_oe, .ad_out, .ad_oe,
        .processor_byte_parity, .processor_parity_check_n, .hit, .terminate, .abort,
        .rd_valid, .rd_ready, .rd_data, .wr_valid, .wr_ready, .wr_word, .cmd,
        .cmd_is_read, .target_abort);

    pts_master_model u_master (.clock, .frame_n, .irdy_n, .ad_in, .cbe_in, .par_in,
        .trdy_n_out, .trdy_oe, .stop_n_out, .stop_oe, .ad_out, .ad_oe, .par_out, .par_oe);

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    function automatic void chk(input bit ok, input string msg);
        comparisons++;
        if (!ok) begin
            bad_count++;
            $display("ERROR %0t %s", $time, msg);
        end
    endfunction

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Event counters let a scenario ask whether a pulse happened at all.
    always @(posedge clock) begin
        if (perr_oe === 1'b1 && perr_n_out === 1'b0) p0 = p0 - 1;
        if (stop_oe === 1'b1 && stop_n_out === 1'b0) s0 = s0 - 1;
        if (devsel_oe === 1'b1 && devsel_n_out === 1'b0) d0 = d0 - 1;
        if (target_abort === 1'b1) t0 = t0 - 1;
        if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
            chk(exp_q.size() > 0 && wr_word === exp_q[0], "write word");
            if (exp_q.size() > 0) void'(exp_q.pop_front());
        end
    end

    task automatic run(input logic [3:0] c, input logic [31:0] d, input logic [3:0] be,
        input bit hold, input bit badp, input bit hv);
        logic [31:0] a;
        a = $random(seed);
        hit = hv;
        if (c[0] && hv && !abort) exp_q.push_back('{data: d, byte_en: be});
        u_master.cycle(c, a, d, be, hold, badp, got, lat, rd);
        hit = 1'b0;
        repeat (6) @(negedge clock);
        chk((trdy_oe | devsel_oe | ad_oe | stop_oe) === 1'b0, "bus held");
        if (hv) chk(cmd === c && cmd_is_read === ~c[0], "command latch");
    endtask

    initial begin
        repeat (20000) @(posedge clock);
        bad_count++;
        $display("ERROR %0t watchdog expired", $time);
        final_report();
    end

    initial begin
        seed = 63942;
        {arst_n, hit, terminate, abort, processor_byte_parity, rd_data} = '0;
        {rd_valid, wr_ready, processor_parity_check_n} = 3'h7;
        repeat (8) @(negedge clock);
        chk(cmd === 4'h0 && (trdy_oe | stop_oe | devsel_oe) === 1'b0, "reset");
        chk((perr_oe | par_oe | ad_oe) === 1'b0, "reset drive");
        chk((trdy_n_out & stop_n_out & devsel_n_out & perr_n_out) === 1'b1, "reset");
        arst_n = 1'b1;
        repeat (3) @(negedge clock);
        for (int i = 0; i < 6; i++) begin
            p0 = 0;
            processor_byte_parity = 4'($random(seed));
            run((i % 2 == 1) ? PTS_CMD_MEM_WRITE : PTS_CMD_IO_WRITE, $random(seed),
                4'($random(seed)), 0, 0, 1);
            chk(got === 1'b1 && p0 == 0, "write phase");
            if (i == 0) wlat = lat;
        end
        p0 = 0;
        run(PTS_CMD_MEM_WRITE, $random(seed), 4'h0, 0, 1, 1);
        chk(p0 < 0, "parity error missed");
        $display("test writes done");
        for (int i = 0; i < 4; i++) begin
            rd_data = $random(seed);
            processor_parity_check_n = (i != 3);
            p0 = 0;
            run((i % 2 == 1) ? PTS_CMD_MEM_READ : PTS_CMD_IO_READ, 32'h0, 4'h0, 0, 0, 1);
            chk(got === 1'b1 && rd === rd_data, "read data");
            chk(lat > wlat, "read wait state");
            chk((p0 < 0) == (i == 3), "read parity check");
        end
        processor_parity_check_n = 1'b1;
        $display("test reads done");
        wr_ready = 1'b0;
        run(PTS_CMD_IO_WRITE, $random(seed), 4'hf, 0, 0, 1);
        run(PTS_CMD_MEM_WRITE, $random(seed), 4'h5, 0, 0, 1);
        n0 = u_master.done_cnt;
        fork
            run(PTS_CMD_MEM_WRITE, $random(seed), 4'ha, 0, 0, 1);
            begin
                repeat (30) @(negedge clock);
                chk(u_master.done_cnt == n0, "full buffer took a word");
                wr_ready = 1'b1;
            end
        join
        chk(got === 1'b1 && exp_q.size() == 0, "stalled write");
        $display("test stall done");
        s0 = 0;
        t0 = 0;
        abort = 1'b1;
        run(PTS_CMD_MEM_READ, 32'h0, 4'h0, 1, 0, 1);
        abort = 1'b0;
        chk(got === 1'b0 && s0 < 0 && t0 < 0, "abort");
        d0 = 0;
        fork
            run(PTS_CMD_IO_WRITE, $random(seed), 4'h3, 0, 0, 0);
            begin
                repeat (5) @(negedge clock);
                hit = 1'b1;
            end
        join
        chk(got === 1'b0 && d0 == 0, "busy answered");
        run(PTS_CMD_IO_WRITE, $random(seed), 4'h3, 0, 0, 1);
        chk(got === 1'b1, "no return to idle");
        s0 = 0;
        terminate = 1'b1;
        @(negedge clock);
        terminate = 1'b0;
        repeat (8) @(negedge clock);
        chk(s0 < 0 && stop_oe === 1'b0, "idle stop");
        chk(exp_q.size() == 0, "words left");
        $display("test stops done");
        final_report();
    end
endmodule
